// ==== verilog/i2c_tmo_pkg.sv ====
// shared constants and types for the i2c bus time-out monitor
package i2c_tmo_pkg;
    localparam int ADDR_W      = 4;
    localparam int DATA_W      = 8;

    // register offsets
    localparam logic [3:0] OFF_TMO_CTRL = 4'h0;
    localparam logic [3:0] OFF_SLV_ADDR = 4'h1;
    localparam logic [3:0] OFF_CTRL1    = 4'h2;
    localparam logic [3:0] OFF_CTRL0    = 4'h3;
    localparam logic [3:0] OFF_DATA     = 4'h4;
    localparam logic [3:0] OFF_INT_STAT = 4'h5;
    localparam logic [3:0] OFF_INT_MASK = 4'h6;

    // i2c_timeout_control fields
    localparam int TMO_EN_BIT   = 7;
    localparam int TMO_FLAG_BIT = 6;
    localparam int TMO_SEL_W    = 6;

    // serial_control_register_1 fields: two flags set by hardware, then the software field
    localparam int CTRL1_HIT_BIT  = 7;
    localparam int CTRL1_BUSY_BIT = 6;
    localparam int CTRL1_SW_W     = 6;

    // interrupt status / mask fields
    localparam int INT_W         = 2;
    localparam int INT_TMO_BIT   = 0;
    localparam int INT_MATCH_BIT = 1;

    // reset values
    localparam logic [7:0] TMO_CTRL_RST = 8'h00;
    localparam logic [7:0] SLV_ADDR_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST    = 8'h00;
    localparam logic [7:0] CTRL0_RST    = 8'h00;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [1:0] INT_RST      = 2'h0;
    localparam logic [7:0] RD_IDLE      = 8'h00;
    localparam logic       PIN_IDLE     = 1'b1;

    // sub clock prescaler and counters
    localparam int         SUB_DIV    = 32;
    localparam int         SUB_DIV_W  = 5;
    localparam logic [4:0] SUB_DIV_LAST = 5'(SUB_DIV - 1);
    localparam int         ADDR_BITS  = 7;
    localparam int         BIT_CNT_W  = 3;
    localparam logic [2:0] ADDR_LAST  = 3'(ADDR_BITS - 1);
    localparam int         TICK_CNT_W = 7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WATCH
    } mon_state_t;
endpackage

// ==== verilog/subclk_prescaler.sv ====
// sub clock synchroniser and divide-by-32 tick generator
module subclk_prescaler
    import i2c_tmo_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic sub_clk_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    logic                 sub_meta;
    logic                 sub_sync;
    logic                 sub_prev;
    logic [SUB_DIV_W-1:0] div_cnt;
    wire                  sub_rise = sub_sync & ~sub_prev;
    wire                  div_wrap = sub_rise & (div_cnt == SUB_DIV_LAST);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_prev <= 1'b0;
        end else if (ce_i) begin
            sub_meta <= sub_clk_i;
            sub_sync <= sub_meta;
            sub_prev <= sub_sync;
        end
    end

    // sub clock over 32
    // clearing the phase keeps each period a whole number of ticks
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            div_cnt <= '0;
            tick_o  <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                div_cnt <= '0;
            end else if (sub_rise) begin
                div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
            end
            tick_o <= div_wrap & ~clr_i;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_tick_divide: assert property (ce_i && div_wrap && !clr_i |=> tick_o && div_cnt == '0)
        else $error("prescaler tick not at divide-by-32 wrap");
endmodule

// ==== verilog/i2c_bus_timeout_monitor.sv ====
// i2c slave bus time-out monitor with register port and interrupt
//
// Decided for this implementation: the placing of the registers and the strobed register port.
module i2c_bus_timeout_monitor
    import i2c_tmo_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    input  wire logic              sub_clk_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rd_data_o,
    output logic                   irq_o,
    output logic                   i2c_logic_reset_o
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        reg_hit = (a == off);
    endfunction

    // pin synchronisers: bit 0 scl, bit 1 sda
    logic [1:0] pin_raw;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    assign pin_raw = {sda_i, scl_i};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    pin_meta[g] <= PIN_IDLE;
                    pin_sync[g] <= PIN_IDLE;
                    pin_prev[g] <= PIN_IDLE;
                end else if (ce_i) begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                    pin_prev[g] <= pin_sync[g];
                end
            end
        end
    endgenerate

    wire scl   = pin_sync[0];
    wire sda   = pin_sync[1];
    wire scl_p = pin_prev[0];
    wire sda_p = pin_prev[1];

    wire start_det = scl & scl_p & sda_p & ~sda;
    wire stop_det  = scl & scl_p & ~sda_p & sda;
    wire scl_fall  = scl_p & ~scl;
    wire scl_rise  = ~scl_p & scl;

    // registers
    logic [7:0]            tmo_ctrl;
    logic [7:0]            slave_addr;
    logic [7:0]            ctrl1;
    logic [7:0]            ctrl0;
    logic [7:0]            data_reg;
    logic [INT_W-1:0]      int_stat;
    logic [INT_W-1:0]      int_mask;
    mon_state_t            state;
    logic [BIT_CNT_W-1:0]  bit_cnt;
    logic [ADDR_BITS-2:0]  addr_shift;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic                  tick;

    wire wr_tmo   = wr_i & reg_hit(addr_i, OFF_TMO_CTRL);
    wire wr_saddr = wr_i & reg_hit(addr_i, OFF_SLV_ADDR);
    wire wr_ctrl1 = wr_i & reg_hit(addr_i, OFF_CTRL1);
    wire wr_ctrl0 = wr_i & reg_hit(addr_i, OFF_CTRL0);
    wire wr_data  = wr_i & reg_hit(addr_i, OFF_DATA);
    wire wr_istat = wr_i & reg_hit(addr_i, OFF_INT_STAT);
    wire wr_imask = wr_i & reg_hit(addr_i, OFF_INT_MASK);

    wire                 tmo_en   = tmo_ctrl[TMO_EN_BIT];
    wire [TMO_SEL_W-1:0] tmo_sel  = tmo_ctrl[TMO_SEL_W-1:0];
    wire                 watching = (state == ST_WATCH) & tmo_en;

    // compare seven received bits with stored address
    wire [ADDR_BITS-1:0] rx_addr    = {addr_shift, sda};
    wire                 addr_done  = (state == ST_ADDR) & scl_rise & (bit_cnt == ADDR_LAST);
    wire                 addr_match = addr_done & (rx_addr == slave_addr[7:1]);

    // period reached before the next scl fall
    // tick count equals select value as the next tick arrives, so the period is select value plus one ticks
    wire timeout_hit = watching & tick & ~scl_fall & (tick_cnt == {1'b0, tmo_sel});

    subclk_prescaler u_presc (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .sub_clk_i  (sub_clk_i),
        .clr_i      (~watching | scl_fall),
        .tick_o     (tick)
    );

    // monitor state machine
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state      <= ST_IDLE;
            bit_cnt    <= '0;
            addr_shift <= '0;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    if (start_det) begin
                        state   <= ST_ADDR;
                        bit_cnt <= '0;
                    end
                end
                ST_ADDR: begin
                    if (stop_det) begin
                        state <= ST_IDLE;
                    end else if (start_det) begin
                        bit_cnt <= '0;
                    end else if (addr_done) begin
                        // start plus match arms the counter
                        state <= addr_match ? ST_WATCH : ST_IDLE;
                    end else if (scl_rise) begin
                        addr_shift <= rx_addr[ADDR_BITS-2:0];
                        bit_cnt    <= bit_cnt + 1'b1;
                    end
                end
                ST_WATCH: begin
                    if (stop_det || timeout_hit) begin
                        state <= ST_IDLE;
                    end else if (start_det) begin
                        state   <= ST_ADDR;
                        bit_cnt <= '0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // time-out counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
        end else if (ce_i) begin
            // held at zero unless enabled and watching
            if (!watching || scl_fall || timeout_hit) begin
                tick_cnt <= '0;
            end else if (tick) begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // time-out control register
    // overflow clears enable and sets flag
    // flag sticky until written zero; set wins
    // no re-arm; enable stays low until written
    wire [7:0] next_tmo_ctrl = timeout_hit ? {1'b0, 1'b1, wr_tmo ? wr_data_i[TMO_SEL_W-1:0] : tmo_sel}
                             : wr_tmo      ? wr_data_i
                             : tmo_ctrl;

    // control register 1 back to reset value on time-out
    wire [7:0] next_ctrl1 = timeout_hit ? CTRL1_RST
                          : {(ctrl1[CTRL1_HIT_BIT] | addr_match) & ~stop_det & ~start_det,
                             (ctrl1[CTRL1_BUSY_BIT] | start_det) & ~stop_det,
                             wr_ctrl1 ? wr_data_i[CTRL1_SW_W-1:0] : ctrl1[CTRL1_SW_W-1:0]};

    // sticky events, write one clears, new event wins
    wire [INT_W-1:0] int_events    = {addr_match, timeout_hit};
    wire [INT_W-1:0] int_clr       = wr_istat ? wr_data_i[INT_W-1:0] : '0;
    wire [INT_W-1:0] next_int_stat = (int_stat & ~int_clr) | int_events;
    wire [INT_W-1:0] next_int_mask = wr_imask ? wr_data_i[INT_W-1:0] : int_mask;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tmo_ctrl   <= TMO_CTRL_RST;
            ctrl1      <= CTRL1_RST;
            int_stat   <= INT_RST;
            int_mask   <= INT_RST;
        end else if (ce_i) begin
            tmo_ctrl   <= next_tmo_ctrl;
            ctrl1      <= next_ctrl1;
            int_stat   <= next_int_stat;
            int_mask   <= next_int_mask;
        end
    end

    // these keep their contents across a time-out
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slave_addr <= SLV_ADDR_RST;
            ctrl0      <= CTRL0_RST;
            data_reg   <= DATA_RST;
        end else if (ce_i) begin
            if (wr_saddr) begin
                slave_addr <= wr_data_i;
            end
            if (wr_ctrl0) begin
                ctrl0 <= wr_data_i;
            end
            if (wr_data) begin
                data_reg <= wr_data_i;
            end
        end
    end

    // read mux, unmapped offsets read zero
    wire [7:0] rd_mux = reg_hit(addr_i, OFF_TMO_CTRL) ? tmo_ctrl
                      : reg_hit(addr_i, OFF_SLV_ADDR) ? slave_addr
                      : reg_hit(addr_i, OFF_CTRL1)    ? ctrl1
                      : reg_hit(addr_i, OFF_CTRL0)    ? ctrl0
                      : reg_hit(addr_i, OFF_DATA)     ? data_reg
                      : reg_hit(addr_i, OFF_INT_STAT) ? {{(8-INT_W){1'b0}}, int_stat}
                      : reg_hit(addr_i, OFF_INT_MASK) ? {{(8-INT_W){1'b0}}, int_mask}
                      : RD_IDLE;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_data_o         <= RD_IDLE;
            irq_o             <= 1'b0;
            i2c_logic_reset_o <= 1'b0;
        end else if (ce_i) begin
            rd_data_o         <= rd_i ? rd_mux : RD_IDLE;
            // time-out shares the i2c interrupt line
            irq_o             <= |(next_int_stat & next_int_mask);
            // one-cycle reset to the i2c shift logic
            i2c_logic_reset_o <= timeout_hit;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_timeout_seen;
        ce_i && timeout_hit;
    endsequence

    sequence s_timeout_effects;
        !tmo_ctrl[TMO_EN_BIT] && tmo_ctrl[TMO_FLAG_BIT] && int_stat[INT_TMO_BIT] && i2c_logic_reset_o;
    endsequence

    // ce low must leave tmo_ctrl, ctrl1, ctrl0, int_stat, state and tick_cnt untouched, pin samples included
    sequence s_state_frozen;
        $stable(tmo_ctrl) && $stable(ctrl1) && $stable(ctrl0) && $stable(int_stat)
        && $stable(state) && $stable(tick_cnt) && $stable(pin_sync);
    endsequence

    a_start_arms: assert property (ce_i && addr_match && !stop_det |=> state == ST_WATCH && tick_cnt == '0)
        else $error("address match did not arm the counter");
    a_fall_clears: assert property (ce_i && watching && scl_fall |=> tick_cnt == '0)
        else $error("scl fall did not clear the counter");
    a_period_hit: assert property (ce_i && watching && tick && !scl_fall && tick_cnt == {1'b0, tmo_sel}
                                   |=> state == ST_IDLE && tmo_ctrl[TMO_FLAG_BIT])
        else $error("period elapsed without time-out");
    a_stop_ends: assert property (ce_i && stop_det |=> state == ST_IDLE)
        else $error("stop did not end monitoring");
    a_overflow_effects: assert property (s_timeout_seen |=> s_timeout_effects)
        else $error("time-out effects missing");
    a_irq_follows: assert property (ce_i |=> irq_o == |(int_stat & int_mask))
        else $error("interrupt output disagrees with status and mask");
    a_ctrl1_reset: assert property (s_timeout_seen |=> ctrl1 == CTRL1_RST)
        else $error("control register 1 not reset on time-out");
    a_regs_kept: assert property ((s_timeout_seen and !wr_i)
                                  |=> $stable(slave_addr) && $stable(ctrl0) && $stable(data_reg))
        else $error("register changed across time-out");
    a_reset_pulse: assert property (ce_i && !timeout_hit |=> !i2c_logic_reset_o)
        else $error("i2c logic reset pulse without a time-out");
    a_match_flags: assert property (ce_i && addr_match |=> int_stat[INT_MATCH_BIT] && ctrl1[CTRL1_HIT_BIT])
        else $error("address match did not set its flags");
    a_flag_sticky: assert property (tmo_ctrl[TMO_FLAG_BIT] && !(ce_i && wr_tmo) |=> tmo_ctrl[TMO_FLAG_BIT])
        else $error("time-out flag dropped without a write");
    a_tick_bound: assert property (watching |-> tick_cnt <= {1'b0, tmo_sel})
        else $error("counter ran past the selected period");
    // the count clears one cycle after software drops the enable mid-frame
    a_disabled_quiet: assert property (ce_i && !tmo_en |-> !timeout_hit ##1 tick_cnt == '0)
        else $error("counter active while disabled");
    a_no_rearm: assert property (ce_i && !tmo_en && !wr_tmo |=> !tmo_en)
        else $error("enable bit re-armed by hardware");
    a_ce_freeze: assert property (!ce_i |=> s_state_frozen)
        else $error("state moved while clock enable low");
    a_rd_idle: assert property (ce_i && !rd_i |=> rd_data_o == RD_IDLE)
        else $error("read data not idle outside a read");
endmodule

// ==== tb/i2c_master_model.sv ====
// behavioural i2c bus master driving the serial clock and data pins
module i2c_master_model #(
    parameter int HALF = 20
) (
    input  wire logic core_clk_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // both lines released to the pull-up level at power-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // start condition
    // data falls while the clock stays high
    task automatic start_cond();
        sda_o <= 1'b1;
        hold(4);
        scl_o <= 1'b1;
        hold(HALF);
        sda_o <= 1'b0;
        hold(HALF);
        scl_o <= 1'b0;
        hold(HALF);
    endtask

    // msb first; data moves only while the clock is low
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            hold(4);
            sda_o <= b[i];
            hold(HALF);
            scl_o <= 1'b1;
            hold(HALF);
            scl_o <= 1'b0;
            // low phase closes here so a following task never re-drives scl in this step
            hold(HALF);
        end
    endtask

    // clock pulses with long low phases, data held steady
    task automatic clk_pulses(input int n, input int low);
        repeat (n) begin
            scl_o <= 1'b1;
            hold(HALF);
            scl_o <= 1'b0;
            hold(low);
        end
    endtask

    task automatic stop_cond();
        hold(4);
        sda_o <= 1'b0;
        hold(HALF);
        scl_o <= 1'b1;
        hold(HALF);
        sda_o <= 1'b1;
        hold(HALF);
    endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the i2c bus time-out monitor
module testbench
    import i2c_tmo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] SLV      = 7'h5A;
    // sub clock deliberately not a multiple of the core period
    localparam int         SUB_HALF = 83;

    logic             core_clk = 1'b0;
    logic             sub_clk  = 1'b0;
    logic             rst      = 1'b1;
    logic             ce       = 1'b1;
    logic             scl;
    logic             sda;
    logic [3:0]       bus_addr = 4'h0;
    logic [7:0]       bus_wdata = 8'h00;
    logic             bus_wr   = 1'b0;
    logic             bus_rd   = 1'b0;
    logic [7:0]       rd_data;
    logic             irq;
    logic             lrst;
    logic             prev_scl = 1'b1;
    int               fails = 0;
    int               samples_checked = 0;
    int               pulses = 0;
    realtime          fall_t = 0;
    realtime          hit_t = 0;
    logic [7:0]       rst_tab [7] = '{TMO_CTRL_RST, SLV_ADDR_RST, CTRL1_RST, CTRL0_RST, DATA_RST,
                                      {6'h00, INT_RST}, {6'h00, INT_RST}};

    always #10 core_clk = ~core_clk;
    always #SUB_HALF sub_clk = ~sub_clk;

    i2c_bus_timeout_monitor dut (
        .core_clk_i        (core_clk),
        .rst_i             (rst),
        .ce_i              (ce),
        .scl_i             (scl),
        .sda_i             (sda),
        .sub_clk_i         (sub_clk),
        .addr_i            (bus_addr),
        .wr_data_i         (bus_wdata),
        .wr_i              (bus_wr),
        .rd_i              (bus_rd),
        .rd_data_o         (rd_data),
        .irq_o             (irq),
        .i2c_logic_reset_o (lrst)
    );

    i2c_master_model master (
        .core_clk_i (core_clk),
        .scl_o      (scl),
        .sda_o      (sda)
    );

    always @(posedge core_clk) begin
        prev_scl <= scl;
        if (prev_scl === 1'b1 && scl === 1'b0) fall_t = $realtime;
        if (lrst === 1'b1) begin
            pulses++;
            hit_t = $realtime;
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr    <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_rd   <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, rd_data);
    endtask

    task automatic wait_hit(input int cycles, output logic hit);
        int n0;
        n0 = pulses;
        hit = 1'b0;
        repeat (cycles) @(posedge core_clk);
        if (pulses != n0) hit = 1'b1;
    endtask

    task automatic run_timeout(input logic [5:0] sel, input logic [7:0] mask);
        real  exp_t;
        real  dt;
        logic hit;
        int   n0;
        wr(OFF_INT_MASK, mask);
        wr(OFF_CTRL1, 8'h15);
        wr(OFF_TMO_CTRL, {2'b10, sel});
        n0 = pulses;
        master.start_cond();
        master.send_byte({SLV, 1'b0});
        master.clk_pulses(2, (int'(sel) + 1) * 200);
        chk("early hit", 8'h00, 8'(pulses - n0));
        wait_hit((int'(sel) + 1) * 300 + 50, hit);
        exp_t = real'((int'(sel) + 1) * 64 * SUB_HALF);
        dt = hit_t - fall_t;
        hit = hit && dt > exp_t - 2 * SUB_HALF - 100 && dt < exp_t + 2 * SUB_HALF + 200;
        chk("timeout window", 8'h01, {7'h00, hit});
        rdchk(OFF_TMO_CTRL, {2'b01, sel});
        rdchk(OFF_CTRL1, CTRL1_RST);
        rdchk(OFF_CTRL0, 8'h3C);
        rdchk(OFF_DATA, 8'hA7);
        rdchk(OFF_SLV_ADDR, {SLV, 1'b1});
        rdchk(OFF_INT_STAT, 8'h03);
        chk("irq raised", {7'h00, mask[0]}, {7'h00, irq});
        wr(OFF_INT_STAT, 8'h03);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", 8'h00, {7'h00, irq});
        repeat (100) @(posedge core_clk);
        rdchk(OFF_TMO_CTRL, {2'b01, sel});
        master.stop_cond();
        wr(OFF_TMO_CTRL, {2'b00, sel});
        rdchk(OFF_TMO_CTRL, {2'b00, sel});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        logic hit;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rdchk(4'(i), rst_tab[i]);
        wr(4'h7, 8'hFF);
        rdchk(4'h7, RD_IDLE);
        wr(OFF_SLV_ADDR, {SLV, 1'b1});
        wr(OFF_CTRL0, 8'h3C);
        wr(OFF_DATA, 8'hA7);
        // a write strobe while the clock enable is low must be ignored
        ce <= 1'b0;
        wr(OFF_CTRL0, 8'h00);
        ce <= 1'b1;
        rdchk(OFF_CTRL0, 8'h3C);
        run_timeout(6'h00, 8'h01);
        run_timeout(6'h3F, 8'h00);
        // enable left clear after the time-out: a matching frame must not arm it
        master.start_cond();
        master.send_byte({SLV, 1'b0});
        wait_hit(400, hit);
        chk("disabled hit", 8'h00, {7'h00, hit});
        rdchk(OFF_INT_STAT, 8'h02);
        master.stop_cond();
        wr(OFF_INT_STAT, 8'h03);
        wr(OFF_TMO_CTRL, 8'h80);
        master.start_cond();
        master.send_byte({SLV, 1'b0});
        master.stop_cond();
        wait_hit(400, hit);
        chk("hit after stop", 8'h00, {7'h00, hit});
        rdchk(OFF_TMO_CTRL, 8'h80);
        wr(OFF_INT_STAT, 8'h03);
        master.start_cond();
        master.send_byte({SLV ^ 7'h01, 1'b0});
        wait_hit(400, hit);
        chk("foreign addr hit", 8'h00, {7'h00, hit});
        rdchk(OFF_INT_STAT, 8'h00);
        master.stop_cond();
        tally_and_finish();
    end
endmodule
